// >>> core/pex_pkg.sv
// constants, types and state codes shared by the port expander access block
package pex_pkg;
	// fixed upper slave address bits per port group
	localparam logic [2:0] GRP_IO_TOP    = 3'h6;
	localparam logic [2:0] GRP_PP_TOP    = 3'h5;
	// connection codes of the four-level address select inputs
	localparam logic [1:0] SEL_GND       = 2'h0;
	localparam logic [1:0] SEL_VCC       = 2'h1;
	localparam logic [1:0] SEL_SCL       = 2'h2;
	localparam logic [1:0] SEL_SDA       = 2'h3;
	localparam logic [1:0] HIGH_SEL_FLIP = 2'h2;
	// serial engine, synchroniser depth and port power-up delay
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam int         SYNC_STAGES   = 2;
	localparam logic [1:0] INIT_CYCLES   = 2'h3;
	// port reset values before the select pins are read
	localparam logic [7:0] IO_OUT_RESET  = 8'hFF;
	localparam logic [7:0] PP_OUT_RESET  = 8'h00;
	// register map, byte addresses
	localparam logic [4:0] ADDR_STATUS   = 5'h00;
	localparam logic [4:0] ADDR_MASK     = 5'h04;
	localparam logic [4:0] ADDR_CTRL     = 5'h08;
	localparam logic [4:0] ADDR_SNAP     = 5'h0C;
	localparam logic [4:0] ADDR_FLAGS    = 5'h10;
	localparam int         ADDR_W        = 5;
	// status, mask and control bit positions, reset values and response codes
	localparam int         ST_CHANGE     = 0;
	localparam int         ST_WRITE      = 1;
	localparam int         ST_READ       = 2;
	localparam int         ST_ABORT      = 3;
	localparam int         ST_W          = 4;
	localparam logic [3:0] MASK_RESET    = 4'h0;
	localparam int         CTRL_EN       = 0;
	localparam logic [0:0] CTRL_RESET    = 1'h1;
	localparam logic [1:0] RESP_OKAY     = 2'h0;
	localparam logic [1:0] RESP_SLVERR   = 2'h2;

	typedef enum logic [6:0] {
		PEX_IDLE     = 7'b0000001,
		PEX_ADDR     = 7'b0000010,
		PEX_ADDR_ACK = 7'b0000100,
		PEX_WR_BYTE  = 7'b0001000,
		PEX_WR_ACK   = 7'b0010000,
		PEX_RD_BYTE  = 7'b0100000,
		PEX_RD_ACK   = 7'b1000000
	} pex_state_e;

	// synchronised view of every pin input
	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       abort_n;
		logic [1:0] sel_high;
		logic [1:0] sel_low;
		logic [7:0] io_in;
		logic [7:0] pp_in;
	} pex_pins_s;
endpackage

// >>> core/pex_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous inputs
`timescale 1ns/1ps
module pex_sync #(
	parameter int W = 1
) (
	input  wire logic         CLK,
	input  wire logic         RESET_N,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

// >>> core/pex_access.sv
// two-wire slave and port access logic of the 16-line port expander
`timescale 1ns/1ps
module pex_access (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic        SCL,
	input  wire logic        SDA_IN,
	output logic             SDA_OUT,
	output logic             SDA_OE,
	input  wire logic [1:0]  ADDR_SEL_HIGH,
	input  wire logic [1:0]  ADDR_SEL_LOW,
	input  wire logic        ABORT_N,
	input  wire logic [7:0]  OPEN_DRAIN_IO_PORTS_IN,
	output logic      [7:0]  OPEN_DRAIN_IO_PORTS_OUT,
	output logic      [7:0]  OPEN_DRAIN_IO_PORTS_OE,
	output logic      [7:0]  PUSH_PULL_OUT_PORTS,
	input  wire logic [7:0]  PUSH_PULL_OUT_PORTS_IN,
	output logic             CHANGE_ALERT_N,
	output logic             IRQ,
	input  wire logic [31:0] AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [31:0] ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY
);
	pex_pkg::pex_pins_s  pins;
	pex_pkg::pex_state_e state;
	logic       scl_q;
	logic       sda_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_cond;
	logic       stop_cond;
	logic       abort;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [7:0] tx;
	logic       sda_drive;
	logic       grp_io;
	logic       in_read;
	logic       ack_ok;
	logic       byte_odd;
	logic       pair_one;
	logic       snap_req;
	logic       wr_strobe;
	logic       rd_done;
	logic [3:0] dev_low;
	logic [7:0] snapshot;
	logic [7:0] flags;
	logic [7:0] flags_prev;
	logic [7:0] pp_sample;
	logic [7:0] io_out;
	logic [7:0] diff;
	logic [1:0] init_cnt;
	logic       ctrl_en;
	logic [3:0] status;
	logic [3:0] mask;
	logic [3:0] ev;
	logic       wr_go;
	logic [4:0] waddr;
	logic [4:0] raddr;
	logic       w_hit;
	logic       r_hit;

	// one synchroniser bundle for every pin input
	pex_sync #(.W($bits(pex_pkg::pex_pins_s))) u_sync (
		.CLK     (CLK),
		.RESET_N (RESET_N),
		.d       ({SCL, SDA_IN, ABORT_N, ADDR_SEL_HIGH, ADDR_SEL_LOW,
		           OPEN_DRAIN_IO_PORTS_IN, PUSH_PULL_OUT_PORTS_IN}),
		.q       (pins)
	);

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			// match the synchroniser's reset level so no start or stop is seen while it fills; one scl rise still shows
			scl_q <= 1'b0;
			sda_q <= 1'b0;
		end else begin
			scl_q <= pins.scl;
			sda_q <= pins.sda;
		end
	end

	assign scl_rise   = pins.scl & ~scl_q;
	assign scl_fall   = ~pins.scl & scl_q;
	assign start_cond = pins.scl & scl_q & sda_q & ~pins.sda;
	assign stop_cond  = pins.scl & scl_q & ~sda_q & pins.sda;
	assign abort      = ~pins.abort_n;

	// select pins are read live, so a pin tied to a bus line decodes on every frame
	assign dev_low = {pins.sel_high ^ pex_pkg::HIGH_SEL_FLIP, pins.sel_low};

	// serial engine: data changes only on clock falls, abort or disable, so outside those it is stable while high
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state     <= pex_pkg::PEX_IDLE;
			bit_cnt   <= 4'h0;
			shift     <= 8'h00;
			tx        <= 8'h00;
			sda_drive <= 1'b0;
			grp_io    <= 1'b0;
			in_read   <= 1'b0;
			ack_ok    <= 1'b0;
			byte_odd  <= 1'b0;
			pair_one  <= 1'b0;
			snap_req  <= 1'b0;
			wr_strobe <= 1'b0;
			rd_done   <= 1'b0;
		end else begin
			snap_req  <= 1'b0;
			wr_strobe <= 1'b0;
			rd_done   <= 1'b0;
			if (abort || !ctrl_en) begin
				state     <= pex_pkg::PEX_IDLE;
				sda_drive <= 1'b0;
				in_read   <= 1'b0;
			end else if (start_cond) begin
				state     <= pex_pkg::PEX_ADDR;
				bit_cnt   <= 4'h0;
				sda_drive <= 1'b0;
				in_read   <= 1'b0;
			end else if (stop_cond) begin
				state     <= pex_pkg::PEX_IDLE;
				sda_drive <= 1'b0;
				in_read   <= 1'b0;
				rd_done   <= in_read;
			end else begin
				case (state)
				pex_pkg::PEX_ADDR, pex_pkg::PEX_WR_BYTE: begin
					if (scl_rise) begin
						shift   <= {shift[6:0], pins.sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == pex_pkg::BITS_PER_BYTE) begin
						bit_cnt <= 4'h0;
						if (state == pex_pkg::PEX_WR_BYTE) begin
							sda_drive <= 1'b1;
							wr_strobe <= 1'b1;
							state     <= pex_pkg::PEX_WR_ACK;
						end else if (shift[7:1] == {pex_pkg::GRP_IO_TOP, dev_low} ||
						             shift[7:1] == {pex_pkg::GRP_PP_TOP, dev_low}) begin
							grp_io    <= (shift[7:5] == pex_pkg::GRP_IO_TOP);
							in_read   <= shift[0];
							sda_drive <= 1'b1;
							snap_req  <= 1'b1;
							state     <= pex_pkg::PEX_ADDR_ACK;
						end else begin
							state <= pex_pkg::PEX_IDLE;
						end
					end
				end
				pex_pkg::PEX_ADDR_ACK: begin
					if (scl_fall) begin
						byte_odd <= 1'b0;
						pair_one <= 1'b1;
						if (in_read) begin
							// the first byte is always port levels
							tx        <= {(grp_io ? snapshot[6:0] : pp_sample[6:0]), 1'b0};
							sda_drive <= grp_io ? ~snapshot[7] : ~pp_sample[7];
							bit_cnt   <= 4'h1;
							state     <= pex_pkg::PEX_RD_BYTE;
						end else begin
							sda_drive <= 1'b0;
							bit_cnt   <= 4'h0;
							state     <= pex_pkg::PEX_WR_BYTE;
						end
					end
				end
				pex_pkg::PEX_WR_ACK: begin
					if (scl_fall) begin
						sda_drive <= 1'b0;
						state     <= pex_pkg::PEX_WR_BYTE;
					end
				end
				pex_pkg::PEX_RD_BYTE: begin
					if (scl_fall) begin
						if (bit_cnt == pex_pkg::BITS_PER_BYTE) begin
							sda_drive <= 1'b0;
							state     <= pex_pkg::PEX_RD_ACK;
						end else begin
							sda_drive <= ~tx[7];
							tx        <= {tx[6:0], 1'b0};
							bit_cnt   <= bit_cnt + 4'h1;
						end
					end
				end
				pex_pkg::PEX_RD_ACK: begin
					if (scl_rise) begin
						ack_ok <= ~pins.sda;
						// resample for the coming byte: push-pull every byte, io after flags
						snap_req <= ~pins.sda & (~grp_io | byte_odd);
					end else if (scl_fall) begin
						if (ack_ok) begin
							byte_odd  <= ~byte_odd;
							bit_cnt   <= 4'h1;
							state     <= pex_pkg::PEX_RD_BYTE;
							if (!grp_io) begin
								tx        <= {pp_sample[6:0], 1'b0};
								sda_drive <= ~pp_sample[7];
							end else if (!byte_odd) begin
								// first pair: flags from before the address ack, later pairs: since resample
								tx        <= {(pair_one ? flags_prev[6:0] : flags[6:0]), 1'b0};
								sda_drive <= pair_one ? ~flags_prev[7] : ~flags[7];
							end else begin
								pair_one  <= 1'b0;
								tx        <= {snapshot[6:0], 1'b0};
								sda_drive <= ~snapshot[7];
							end
						end else begin
							// master declined more data; wait for its stop
							state <= pex_pkg::PEX_IDLE;
						end
					end
				end
				default: begin
					state     <= pex_pkg::PEX_IDLE;
					sda_drive <= 1'b0;
				end
				endcase
			end
		end
	end

	assign SDA_OUT = 1'b0;
	assign SDA_OE  = sda_drive;

	// snapshot and transition flags; a change in the clearing cycle is not flagged, it only shows in the snapshot
	assign diff = snapshot ^ pins.io_in;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			snapshot   <= 8'h00;
			flags      <= 8'h00;
			flags_prev <= 8'h00;
			pp_sample  <= 8'h00;
		end else if (snap_req) begin
			snapshot   <= pins.io_in;
			flags_prev <= flags;
			flags      <= 8'h00;
			pp_sample  <= pins.pp_in;
		end else begin
			flags <= flags | diff;
		end
	end

	// alert held off for a whole read; it comes back by itself once the stop clears in_read
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			CHANGE_ALERT_N <= 1'b1;
		end else begin
			CHANGE_ALERT_N <= ~((|flags) & ~in_read);
		end
	end

	// port outputs: power-up defaults taken once the select pins have settled
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			init_cnt            <= 2'h0;
			io_out              <= pex_pkg::IO_OUT_RESET;
			PUSH_PULL_OUT_PORTS <= pex_pkg::PP_OUT_RESET;
		end else if (init_cnt != pex_pkg::INIT_CYCLES) begin
			init_cnt <= init_cnt + 2'h1;
			if (init_cnt + 2'h1 == pex_pkg::INIT_CYCLES) begin
				io_out <= {{4{pins.sel_high != pex_pkg::SEL_GND}},
				           {4{pins.sel_low != pex_pkg::SEL_GND}}};
				PUSH_PULL_OUT_PORTS <= {{4{pins.sel_high != pex_pkg::SEL_GND}},
				                        {4{pins.sel_low != pex_pkg::SEL_GND}}};
			end
		end else if (wr_strobe) begin
			if (grp_io) begin
				io_out <= shift;
			end else begin
				PUSH_PULL_OUT_PORTS <= shift;
			end
		end
	end

	assign OPEN_DRAIN_IO_PORTS_OUT = 8'h00;
	assign OPEN_DRAIN_IO_PORTS_OE  = ~io_out;

	// sticky status, set wins over a write-one clear in the same cycle
	assign ev = {abort & (state != pex_pkg::PEX_IDLE), rd_done, wr_strobe,
	             |(diff & ~flags)};

	assign waddr = AWADDR[4:0];
	assign raddr = ARADDR[4:0];
	assign wr_go = AWVALID & WVALID & ~BVALID;
	assign w_hit = (AWADDR[31:5] == 27'h0) && (waddr == pex_pkg::ADDR_STATUS ||
	               waddr == pex_pkg::ADDR_MASK || waddr == pex_pkg::ADDR_CTRL);
	assign r_hit = (ARADDR[31:5] == 27'h0) && (raddr == pex_pkg::ADDR_STATUS ||
	               raddr == pex_pkg::ADDR_MASK || raddr == pex_pkg::ADDR_CTRL ||
	               raddr == pex_pkg::ADDR_SNAP || raddr == pex_pkg::ADDR_FLAGS);
	assign AWREADY = wr_go;
	assign WREADY  = wr_go;
	assign ARREADY = ~RVALID;

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			status  <= 4'h0;
			mask    <= pex_pkg::MASK_RESET;
			ctrl_en <= pex_pkg::CTRL_RESET[0];
			BVALID  <= 1'b0;
			BRESP   <= pex_pkg::RESP_OKAY;
		end else begin
			if (wr_go && WSTRB[0] && waddr == pex_pkg::ADDR_STATUS && w_hit) begin
				status <= (status & ~WDATA[3:0]) | ev;
			end else begin
				status <= status | ev;
			end
			if (wr_go && WSTRB[0] && waddr == pex_pkg::ADDR_MASK && w_hit) begin
				mask <= WDATA[3:0];
			end
			if (wr_go && WSTRB[0] && waddr == pex_pkg::ADDR_CTRL && w_hit) begin
				ctrl_en <= WDATA[pex_pkg::CTRL_EN];
			end
			if (wr_go) begin
				BVALID <= 1'b1;
				BRESP  <= w_hit ? pex_pkg::RESP_OKAY : pex_pkg::RESP_SLVERR;
			end else if (BREADY) begin
				BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RVALID <= 1'b0;
			RDATA  <= 32'h0;
			RRESP  <= pex_pkg::RESP_OKAY;
		end else if (ARVALID && !RVALID) begin
			RVALID <= 1'b1;
			RRESP  <= r_hit ? pex_pkg::RESP_OKAY : pex_pkg::RESP_SLVERR;
			case (raddr)
			pex_pkg::ADDR_STATUS: RDATA <= {28'h0, status};
			pex_pkg::ADDR_MASK:   RDATA <= {28'h0, mask};
			pex_pkg::ADDR_CTRL:   RDATA <= {31'h0, ctrl_en};
			pex_pkg::ADDR_SNAP:   RDATA <= {24'h0, snapshot};
			pex_pkg::ADDR_FLAGS:  RDATA <= {24'h0, flags};
			default:              RDATA <= 32'h0;
			endcase
			if (!r_hit) begin
				RDATA <= 32'h0;
			end
		end else if (RREADY) begin
			RVALID <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |(status & mask);
		end
	end
endmodule

// >>> sim/pex_access_props.sv
// pin-level assertions and covers for the port expander access block
`timescale 1ns/1ps
module pex_access_props (
	input wire logic       CLK,
	input wire logic       RESET_N,
	input wire logic       SCL,
	input wire logic       SDA_IN,
	input wire logic       SDA_OUT,
	input wire logic       SDA_OE,
	input wire logic [1:0] ADDR_SEL_HIGH,
	input wire logic [1:0] ADDR_SEL_LOW,
	input wire logic       ABORT_N,
	input wire logic [7:0] OPEN_DRAIN_IO_PORTS_IN,
	input wire logic [7:0] OPEN_DRAIN_IO_PORTS_OUT,
	input wire logic [7:0] OPEN_DRAIN_IO_PORTS_OE,
	input wire logic [7:0] PUSH_PULL_OUT_PORTS,
	input wire logic       CHANGE_ALERT_N,
	input wire logic       BVALID,
	input wire logic       BREADY,
	input wire logic [1:0] BRESP
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	logic       scl_q;
	logic       sda_q;
	logic       busy;
	logic [3:0] up;
	logic [7:0] dflt;
	assign dflt = {{4{ADDR_SEL_HIGH != pex_pkg::SEL_GND}}, {4{ADDR_SEL_LOW != pex_pkg::SEL_GND}}};
	// frame tracking on the raw lines; up masks the power-up load of the port defaults
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			busy  <= 1'b0;
			up    <= 4'h0;
		end else begin
			scl_q <= SCL;
			sda_q <= SDA_IN;
			up    <= (up == 4'hF) ? up : up + 4'h1;
			if (SCL && scl_q && sda_q != SDA_IN)
				busy <= sda_q;
		end
	end
	a_sda_pull_only: assert property (SDA_OUT == 1'b0)
		else $error("data line driven high");
	a_io_pull_only: assert property (OPEN_DRAIN_IO_PORTS_OUT == 8'h00)
		else $error("io port driven high");
	a_oe_rise_scl_low: assert property ($rose(SDA_OE) |-> !SCL && !$past(SCL))
		else $error("data pulled low while clock high");
	a_oe_steady_high: assert property (SCL && $past(SCL) && ABORT_N && $past(ABORT_N, 4) |-> $stable(SDA_OE))
		else $error("data moved while clock high");
	a_abort_release: assert property ((!ABORT_N) [*6] |-> !SDA_OE)
		else $error("data held during abort");
	a_alert_on_change: assert property ($changed(OPEN_DRAIN_IO_PORTS_IN) && !busy && up == 4'hF
		|-> ##[1:6] (!CHANGE_ALERT_N || busy))
		else $error("input change gave no alert");
	a_pp_default: assert property ($rose(RESET_N) |-> ##[3:6] PUSH_PULL_OUT_PORTS == dflt)
		else $error("push-pull power-up level wrong");
	a_io_default: assert property ($rose(RESET_N) |-> ##[3:6] OPEN_DRAIN_IO_PORTS_OE == ~dflt)
		else $error("io power-up level wrong");
	a_bvalid_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped early");
	c_ack: cover property ($rose(SDA_OE));
	c_alert: cover property ($fell(CHANGE_ALERT_N));
	c_abort: cover property ($fell(ABORT_N) && busy);
endmodule
bind pex_access pex_access_props pex_access_props_inst (.CLK(CLK), .RESET_N(RESET_N), .SCL(SCL), .SDA_IN(SDA_IN),
	.SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDR_SEL_HIGH(ADDR_SEL_HIGH), .ADDR_SEL_LOW(ADDR_SEL_LOW),
	.ABORT_N(ABORT_N), .OPEN_DRAIN_IO_PORTS_IN(OPEN_DRAIN_IO_PORTS_IN),
	.OPEN_DRAIN_IO_PORTS_OUT(OPEN_DRAIN_IO_PORTS_OUT), .OPEN_DRAIN_IO_PORTS_OE(OPEN_DRAIN_IO_PORTS_OE),
	.PUSH_PULL_OUT_PORTS(PUSH_PULL_OUT_PORTS), .CHANGE_ALERT_N(CHANGE_ALERT_N), .BVALID(BVALID),
	.BREADY(BREADY), .BRESP(BRESP));

// >>> sim/pex_i2c_master.sv
// behavioural two-wire bus master, clock still and high between frames
`timescale 1ns/1ps
module pex_i2c_master (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	logic [8:0] res;
	event       done;
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// data moves mid low phase, read at the end of the high phase
	task automatic bit_io(input logic b, output logic r);
		#20 sda_low = !b;
		#42.5 scl = 1'b1;
		#62.5 r = sda;
		scl = 1'b0;
	endtask
	task automatic start;
		#62.5 sda_low = 1'b1;
		#62.5 scl = 1'b0;
	endtask
	task automatic stop;
		#20 sda_low = 1'b1;
		#42.5 scl = 1'b1;
		#62.5 sda_low = 1'b0;
		#62.5;
	endtask
	// eight bits then the ninth, which is our ack when reading
	task automatic xfer(input logic [7:0] d, input logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], res[i+1]);
		bit_io(a, res[0]);
		->done;
	endtask
endmodule

// >>> sim/tb_top.sv
// self-checking bench: serial frames, port loopback, register bus and abort
`timescale 1ns/1ps
module tb_top;
	logic        clk, reset_n, abort_n, scl, sda, sda_low, sda_oe, irq, alert_n;
	logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0]  sel_hi, sel_lo, bresp, rresp;
	logic [1:0]  hi_map [4] = '{2'h2, 2'h3, 2'h0, 2'h1};
	logic [6:0]  a_io, a_pp;
	logic [7:0]  io_ext, io_oe, pp_out, pp_force, dflt, e0, e1, e2, d1, d2, rnd;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [33:0] exp_w[$];
	logic [8:0]  exp_s[$];
	int          n_errors, checks_done, cycles, seed, k;
	// open-drain data line with its pull-up
	assign sda = !(sda_low || sda_oe);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	pex_access pex_access_inst (.CLK(clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
		.ADDR_SEL_HIGH(sel_hi), .ADDR_SEL_LOW(sel_lo), .ABORT_N(abort_n), .OPEN_DRAIN_IO_PORTS_IN(io_ext & ~io_oe),
		.OPEN_DRAIN_IO_PORTS_OUT(), .OPEN_DRAIN_IO_PORTS_OE(io_oe), .PUSH_PULL_OUT_PORTS(pp_out),
		.PUSH_PULL_OUT_PORTS_IN(pp_out ^ pp_force), .CHANGE_ALERT_N(alert_n), .IRQ(irq), .AWADDR(awaddr),
		.AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid), .WREADY(wready),
		.BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
		.RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
	pex_i2c_master pex_i2c_master_inst (.scl(scl), .sda_low(sda_low), .sda(sda));
	task automatic give_verdict;
		$display("mismatches %0d of %0d checks", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic tally(input logic ok, input string what);
		checks_done++;
		if (!ok) begin
			n_errors++;
			$display("MISMATCH at %0t: %s", $time, what);
		end
	endtask
	task automatic chk_word(input logic [33:0] got, input logic [33:0] exp);
		tally(got === exp, "bus response");
	endtask
	task automatic chk_ser(input logic [8:0] got, input logic [8:0] exp);
		tally(got === exp, "serial byte");
	endtask
	task automatic chk_lvl(input logic got, input logic exp);
		tally(got === exp, "pin level");
	endtask
	always @(posedge clk) begin
		if (bvalid && bready)
			chk_word({bresp, 32'h0}, exp_w.pop_front());
		if (rvalid && rready)
			chk_word({rresp, rdata}, exp_w.pop_front());
	end
	always @(pex_i2c_master_inst.done)
		chk_ser(pex_i2c_master_inst.res, exp_s.pop_front());
	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			give_verdict;
		end
	end
	task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] rsp);
		@(posedge clk);
		exp_w.push_back({rsp, 32'h0});
		awaddr <= {27'h0, a};
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge clk); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [4:0] a, input logic [33:0] exp);
		@(posedge clk);
		exp_w.push_back(exp);
		araddr <= {27'h0, a};
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		@(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		rready <= 1'b0;
	endtask
	task automatic ser(input logic [7:0] d, input logic a, input logic [8:0] exp);
		exp_s.push_back(exp);
		pex_i2c_master_inst.xfer(d, a);
	endtask
	task automatic hdr(input logic [6:0] a, input logic rw, input logic nak);
		pex_i2c_master_inst.start;
		ser({a, rw}, 1'b1, {a, rw, nak});
	endtask
	initial begin
		seed = 63267;
		{reset_n, awvalid, wvalid, bready, arvalid, rready, sel_hi, sel_lo, pp_force} = '0;
		{awaddr, wdata, araddr} = '0;
		abort_n = 1'b1;
		io_ext = 8'hFF;
		for (k = 0; k < 4; k++) begin
			@(posedge clk);
			sel_hi <= k[1:0];
			sel_lo <= 2'h3 - k[1:0];
			reset_n <= 1'b0;
			repeat (12) @(posedge clk);
			reset_n <= 1'b1;
			repeat (6) @(posedge clk);
			dflt = {{4{sel_hi != 2'h0}}, {4{sel_lo != 2'h0}}};
			a_io = {3'b110, hi_map[sel_hi], sel_lo};
			a_pp = {3'b101, hi_map[sel_hi], sel_lo};
			hdr(a_pp, 1'b1, 1'b0);
			ser(8'hFF, 1'b1, {dflt, 1'b1});
			pex_i2c_master_inst.stop;
			hdr(a_io, 1'b1, 1'b0);
			ser(8'hFF, 1'b1, {dflt, 1'b1});
			pex_i2c_master_inst.stop;
			hdr(a_io ^ (k[0] ? 7'h10 : 7'h01), 1'b0, 1'b1);
			pex_i2c_master_inst.stop;
		end
		axi_rd(pex_pkg::ADDR_MASK, {pex_pkg::RESP_OKAY, 32'h0});
		axi_rd(pex_pkg::ADDR_CTRL, {pex_pkg::RESP_OKAY, 31'h0, pex_pkg::CTRL_RESET});
		axi_rd(5'h14, {pex_pkg::RESP_SLVERR, 32'h0});
		axi_wr(5'h14, 32'hFFFF_FFFF, pex_pkg::RESP_SLVERR);
		d1 = 8'($random(seed));
		d2 = 8'($random(seed));
		rnd = 8'($random(seed)) | 8'h01;
		hdr(a_pp, 1'b0, 1'b0);
		ser(d1, 1'b1, {d1, 1'b0});
		ser(d2, 1'b1, {d2, 1'b0});
		pex_i2c_master_inst.stop;
		@(posedge clk);
		pp_force <= rnd;
		hdr(a_pp, 1'b1, 1'b0);
		ser(8'hFF, 1'b0, {d2 ^ rnd, 1'b0});
		ser(8'hFF, 1'b1, {d2 ^ rnd, 1'b1});
		pex_i2c_master_inst.stop;
		hdr(a_io, 1'b0, 1'b0);
		ser(8'hFF, 1'b1, {8'hFF, 1'b0});
		pex_i2c_master_inst.stop;
		e0 = 8'($random(seed)) & 8'h7F;
		e1 = e0 ^ (8'($random(seed)) | 8'h01);
		e2 = e1 ^ (8'($random(seed)) | 8'h80);
		@(posedge clk);
		io_ext <= e0;
		pp_force <= 8'h00;
		hdr(a_io, 1'b1, 1'b0);
		ser(8'hFF, 1'b1, {e0, 1'b1});
		pex_i2c_master_inst.stop;
		@(posedge clk);
		chk_lvl(alert_n, 1'b1);
		axi_wr(pex_pkg::ADDR_MASK, 32'h1, pex_pkg::RESP_OKAY);
		axi_wr(pex_pkg::ADDR_STATUS, 32'h1, pex_pkg::RESP_OKAY);
		@(posedge clk);
		chk_lvl(irq, 1'b0);
		io_ext <= e1;
		repeat (8) @(posedge clk);
		chk_lvl(alert_n, 1'b0);
		chk_lvl(irq, 1'b1);
		axi_rd(pex_pkg::ADDR_FLAGS, {pex_pkg::RESP_OKAY, 24'h0, e0 ^ e1});
		axi_wr(pex_pkg::ADDR_MASK, 32'h0, pex_pkg::RESP_OKAY);
		@(posedge clk);
		chk_lvl(irq, 1'b0);
		hdr(a_io, 1'b1, 1'b0);
		chk_lvl(alert_n, 1'b1);
		ser(8'hFF, 1'b0, {e1, 1'b0});
		ser(8'hFF, 1'b0, {e0 ^ e1, 1'b0});
		fork
			ser(8'hFF, 1'b0, {e1, 1'b0});
			begin
				repeat (50) @(posedge clk);
				io_ext <= e2;
			end
		join
		chk_lvl(alert_n, 1'b1);
		ser(8'hFF, 1'b1, {e1 ^ e2, 1'b1});
		pex_i2c_master_inst.stop;
		repeat (4) @(posedge clk);
		chk_lvl(alert_n, 1'b0);
		// abort after the address is taken: the data byte that follows must go unanswered
		hdr(a_pp, 1'b0, 1'b0);
		@(posedge clk);
		abort_n <= 1'b0;
		repeat (8) @(posedge clk);
		abort_n <= 1'b1;
		repeat (4) @(posedge clk);
		ser(8'h5A, 1'b1, {8'h5A, 1'b1});
		pex_i2c_master_inst.stop;
		// the matched address ack already cleared the flags; abort must leave the alert there
		chk_lvl(alert_n, 1'b1);
		hdr(a_pp, 1'b1, 1'b0);
		ser(8'hFF, 1'b1, {d2, 1'b1});
		pex_i2c_master_inst.stop;
		// slave disabled: a matching address goes unanswered
		axi_wr(pex_pkg::ADDR_CTRL, 32'h0, pex_pkg::RESP_OKAY);
		axi_rd(pex_pkg::ADDR_CTRL, {pex_pkg::RESP_OKAY, 32'h0});
		hdr(a_pp, 1'b1, 1'b1);
		pex_i2c_master_inst.stop;
		axi_wr(pex_pkg::ADDR_CTRL, 32'h1, pex_pkg::RESP_OKAY);
		hdr(a_pp, 1'b1, 1'b0);
		ser(8'hFF, 1'b1, {d2, 1'b1});
		pex_i2c_master_inst.stop;
		repeat (4) @(posedge clk);
		give_verdict;
	end
endmodule
